// ### hdl/iwd_prediv.sv
`timescale 1ns/100ps
module iwd_prediv import iwd_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_clk_en,
   iwd_if.div       bus
);
   logic [DIV_W-1:0] div_cnt_reg;
   logic [DIV_W-1:0] div_cnt_next;
   logic [DIV_W-1:0] ratio_m1;

   // divide by 4 doubling up to 128, 256 for the top two codes
   always_comb
   begin
      if (bus.psel >= PS_SAT)
         ratio_m1 = DIV_MAX_M1;
      else
         ratio_m1 = (DIV_BASE << bus.psel) - DIV_ONE;
   end

   // counter advances only on oscillator edges
   assign bus.cnt_tick = bus.osc_tick & ~bus.clear
                       & (div_cnt_reg >= ratio_m1);

   always_comb
   begin
      div_cnt_next = div_cnt_reg;
      if (bus.clear)
         div_cnt_next = DIV_ZERO;
      else if (bus.cnt_tick)
         div_cnt_next = DIV_ZERO;
      else if (bus.osc_tick)
         div_cnt_next = div_cnt_reg + DIV_ONE;
   end

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         div_cnt_reg <= DIV_ZERO;
      else if (i_clk_en)
         div_cnt_reg <= div_cnt_next;
   end

   div_sat_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (bus.psel >= PS_SAT) |-> ratio_m1 == DIV_MAX_M1)
      else $error("divider not 256 for top codes");
   div_base_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (bus.psel == PRESC_RESET) |-> ratio_m1 == DIV_BASE - DIV_ONE)
      else $error("divider not 4 for code zero");
   tick_osc_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      bus.cnt_tick && i_clk_en |-> bus.osc_tick ##1 div_cnt_reg == DIV_ZERO)
      else $error("counter tick without oscillator edge");
endmodule : iwd_prediv

// ### hdl/iwd_watchdog.sv
//
// Function
// - reload key copies the reload value into the down-counter.
// - unlock key grants write access to prescaler and reload registers.
// - start key runs the counter; no effect in hardware watchdog mode.
// - prescaler code divides oscillator by 4..128, codes 6 and 7 by 256.
// - timeout set by 12-bit reload and divider; reload resets to 0xFFF.
// - reload busy flag in bit 1 is high while a reload update runs.
// - prescaler busy flag in bit 0 is high while a prescaler update runs.
// - busy flags work whether or not the watchdog is started.
// - key register is write-only, 16 bits, resets to zero.
// - counter starts from 0xFFF; reset asserted on the next divided tick after it reaches zero.
// - any key other than unlock restores write protection.
// - hardware watchdog option starts counting at power-on automatically.
// - counter is clocked from the low-speed oscillator.
//
`timescale 1ns/100ps
module iwd_watchdog import iwd_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_clk_en,
   input  wire logic              i_low_speed_oscillator,
   input  wire logic              i_hw_watchdog,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   output logic                   o_watchdog_reset_out,
   output logic                   o_running
);
   iwd_if div_bus ();

   iwd_state_e       state_reg;
   iwd_state_e       state_next;
   logic [1:0]       strap_cnt_reg;
   logic             osc_s1_reg;
   logic             osc_s2_reg;
   logic             osc_s3_reg;
   logic             hw_s1_reg;
   logic             hw_s2_reg;
   logic             osc_tick;
   logic             unlock_reg;
   logic [PS_W-1:0]  ps_shadow_reg;
   logic [PS_W-1:0]  ps_active_reg;
   logic             ps_busy_reg;
   logic [RL_W-1:0]  rl_shadow_reg;
   logic [RL_W-1:0]  rl_active_reg;
   logic             rl_busy_reg;
   logic [RL_W-1:0]  cnt_reg;
   logic             fire_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [KEY_W-1:0] key_val;
   logic             key_wr;
   logic             ps_wr_ok;
   logic             rl_wr_ok;
   logic             reload_cmd;
   logic             running;

   // oscillator pin through three flip-flops, strap pin through two
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         osc_s1_reg <= 1'b0;
         osc_s2_reg <= 1'b0;
         osc_s3_reg <= 1'b0;
         hw_s1_reg  <= 1'b0;
         hw_s2_reg  <= 1'b0;
      end
      else if (i_clk_en)
      begin
         osc_s1_reg <= i_low_speed_oscillator;
         osc_s2_reg <= osc_s1_reg;
         osc_s3_reg <= osc_s2_reg;
         hw_s1_reg  <= i_hw_watchdog;
         hw_s2_reg  <= hw_s1_reg;
      end
   end

   // rising oscillator edge, the counter domain's clock event
   assign osc_tick = osc_s2_reg & ~osc_s3_reg;

   // bus decode
   assign key_val    = i_wdata[KEY_W-1:0];
   assign key_wr     = i_wr & (i_addr == OFF_KEY);
   assign reload_cmd = key_wr & (key_val == KEY_RELOAD);
   assign ps_wr_ok   = i_wr & (i_addr == OFF_DIV) & unlock_reg;
   assign rl_wr_ok   = i_wr & (i_addr == OFF_RLD) & unlock_reg;
   assign running    = (state_reg == ST_RUN);

   // write permission for prescaler and reload
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         unlock_reg <= 1'b0;
      else if (i_clk_en && key_wr)
         unlock_reg <= (key_val == KEY_UNLOCK);
   end

   // prescaler shadow and applied value
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ps_shadow_reg <= PRESC_RESET;
         ps_active_reg <= PRESC_RESET;
         ps_busy_reg   <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (ps_wr_ok)
            ps_shadow_reg <= i_wdata[PS_W-1:0];
         if (osc_tick)
            ps_active_reg <= ps_shadow_reg;
         ps_busy_reg <= ps_wr_ok | (ps_busy_reg & ~osc_tick);
      end
   end

   // reload shadow and applied value
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rl_shadow_reg <= RELOAD_RESET;
         rl_active_reg <= RELOAD_RESET;
         rl_busy_reg   <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (rl_wr_ok)
            rl_shadow_reg <= i_wdata[RL_W-1:0];
         if (osc_tick)
            rl_active_reg <= rl_shadow_reg;
         rl_busy_reg <= rl_wr_ok | (rl_busy_reg & ~osc_tick);
      end
   end

   // prescaler divider
   assign div_bus.osc_tick = osc_tick;
   assign div_bus.clear    = ~running;
   assign div_bus.psel     = ps_active_reg;

   iwd_prediv u_prediv
   (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_clk_en   (i_clk_en),
      .bus        (div_bus.div)
   );

   // watchdog control
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_STRAP:
         begin
            if (strap_cnt_reg == STRAP_CAPTURE)
               state_next = hw_s2_reg ? ST_RUN : ST_IDLE;
         end
         ST_IDLE:
         begin
            if (key_wr && key_val == KEY_START)
               state_next = ST_RUN;
         end
         ST_RUN:
         begin
            if (!reload_cmd && div_bus.cnt_tick && cnt_reg == CNT_END)
               state_next = ST_FIRED;
         end
         ST_FIRED:
         begin
            state_next = ST_FIRED;
         end
         default:
         begin
            state_next = ST_STRAP;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         state_reg <= ST_STRAP;
      else if (i_clk_en)
         state_reg <= state_next;
   end

   // strap settling count after reset release
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         strap_cnt_reg <= 2'h0;
      else if (i_clk_en && state_reg == ST_STRAP)
         strap_cnt_reg <= strap_cnt_reg + STRAP_ONE;
   end

   // down-counter
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         cnt_reg <= RELOAD_RESET;
      else if (i_clk_en)
      begin
         if (reload_cmd)
            cnt_reg <= rl_active_reg;
         else if (running && div_bus.cnt_tick && cnt_reg != CNT_END)
            cnt_reg <= cnt_reg - CNT_ONE;
      end
   end

   // sticky reset request
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         fire_reg <= 1'b0;
      else if (i_clk_en && state_next == ST_FIRED)
         fire_reg <= 1'b1;
   end

   // read data, valid only in the cycle after the strobe
   always_comb
   begin
      rdata_next = RDATA_ZERO;
      if (i_rd)
      begin
         case (i_addr)
            OFF_KEY:
               rdata_next = RDATA_ZERO;
            OFF_DIV:
               rdata_next = DATA_W'(ps_active_reg);
            OFF_RLD:
               rdata_next = DATA_W'(rl_active_reg);
            OFF_STAT:
            begin
               rdata_next[PVU_BIT] = ps_busy_reg;
               rdata_next[RVU_BIT] = rl_busy_reg;
            end
            default:
               rdata_next = RDATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         rdata_reg <= RDATA_ZERO;
      else if (i_clk_en)
         rdata_reg <= rdata_next;
   end

   assign o_rdata              = rdata_reg;
   assign o_watchdog_reset_out = fire_reg;
   assign o_running            = running;

   // checks
   reload_load_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && reload_cmd |=> cnt_reg == $past(rl_active_reg))
      else $error("reload key did not load counter");

   unlock_grant_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && key_wr && key_val == KEY_UNLOCK |=> unlock_reg)
      else $error("unlock key did not grant access");

   start_run_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && state_reg == ST_IDLE && key_wr && key_val == KEY_START
      |=> o_running)
      else $error("start key did not start counter");

   reload_reset_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      $rose(i_resetn) |-> rl_active_reg == RELOAD_RESET
                          && cnt_reg == RELOAD_RESET)
      else $error("reload or counter reset value wrong");

   rl_busy_set_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && rl_wr_ok
      |=> rl_busy_reg)
      else $error("reload busy not raised");

   ps_busy_set_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && ps_wr_ok |=> ps_busy_reg)
      else $error("prescaler busy not raised");

   key_reads_zero_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && i_rd && i_addr == OFF_KEY |=> o_rdata == RDATA_ZERO)
      else $error("key register read not zero");

   timeout_fire_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && running && div_bus.cnt_tick && cnt_reg == CNT_END
      && !reload_cmd |=> o_watchdog_reset_out ##1 o_watchdog_reset_out)
      else $error("no reset at counter end");

   fire_hold_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      o_watchdog_reset_out
      |=> o_watchdog_reset_out && !o_running)
      else $error("watchdog reset request not held");

   relock_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && key_wr && key_val != KEY_UNLOCK |=> !unlock_reg)
      else $error("write protection not restored");

   hw_start_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && state_reg == ST_STRAP && strap_cnt_reg == STRAP_CAPTURE
      && hw_s2_reg |=> o_running)
      else $error("hardware option did not start counter");

   rl_apply_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && rl_busy_reg && osc_tick && !rl_wr_ok
      |=> !rl_busy_reg && rl_active_reg == $past(rl_shadow_reg))
      else $error("reload update not applied on oscillator edge");

   locked_ignore_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      i_clk_en && i_wr && i_addr == OFF_RLD && !unlock_reg
      |=> $stable(rl_shadow_reg))
      else $error("locked reload write took effect");

   freeze_en_a: assert property (@(posedge i_core_clk)
      disable iff (!i_resetn)
      !i_clk_en |=> $stable(cnt_reg) && $stable(state_reg))
      else $error("state moved with clock enable low");
endmodule : iwd_watchdog

// ### inc/iwd_if.sv
`timescale 1ns/100ps
interface iwd_if import iwd_pkg::*; ();
   logic            osc_tick;
   logic            clear;
   logic [PS_W-1:0] psel;
   logic            cnt_tick;
   modport ctl
   (
      output osc_tick,
      output clear,
      output psel,
      input  cnt_tick
   );
   modport div
   (
      input  osc_tick,
      input  clear,
      input  psel,
      output cnt_tick
   );
endinterface : iwd_if

// ### inc/iwd_pkg.sv
package iwd_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int KEY_W  = 16;
   localparam int RL_W   = 12;
   localparam int PS_W   = 3;
   localparam int DIV_W  = 8;
   localparam logic [ADDR_W-1:0] OFF_KEY  = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_DIV  = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_RLD  = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_STAT = 4'hC;
   localparam logic [KEY_W-1:0]  KEY_RELOAD = 16'hAAAA;
   localparam logic [KEY_W-1:0]  KEY_UNLOCK = 16'h5555;
   localparam logic [KEY_W-1:0]  KEY_START  = 16'hCCCC;
   localparam logic [RL_W-1:0]   RELOAD_RESET = 12'hFFF;
   localparam logic [RL_W-1:0]   CNT_END      = 12'h000;
   localparam logic [RL_W-1:0]   CNT_ONE      = 12'h001;
   localparam logic [PS_W-1:0]   PRESC_RESET  = 3'h0;
   localparam logic [PS_W-1:0]   PS_SAT       = 3'h6;
   localparam logic [DIV_W-1:0]  DIV_BASE     = 8'h04;
   localparam logic [DIV_W-1:0]  DIV_ONE      = 8'h01;
   localparam logic [DIV_W-1:0]  DIV_ZERO     = 8'h00;
   localparam logic [DIV_W-1:0]  DIV_MAX_M1   = 8'hFF;
   localparam logic [DATA_W-1:0] RDATA_ZERO   = 32'h0000_0000;
   localparam int PVU_BIT = 0;
   localparam int RVU_BIT = 1;
   localparam logic [1:0] STRAP_CAPTURE = 2'h2;
   localparam logic [1:0] STRAP_ONE     = 2'h1;
   typedef enum logic [1:0]
   {
      ST_STRAP = 2'b00,
      ST_IDLE  = 2'b01,
      ST_RUN   = 2'b10,
      ST_FIRED = 2'b11
   } iwd_state_e;
endpackage : iwd_pkg

// ### testbench/iwd_watchdog_tb_top.sv
`timescale 1ns/100ps
module iwd_watchdog_tb_top import iwd_pkg::*;;
   logic              i_core_clk             = 1'b0;
   logic              i_resetn               = 1'b0;
   logic              i_clk_en               = 1'b1;
   logic              i_low_speed_oscillator = 1'b0;
   logic              i_hw_watchdog          = 1'b0;
   logic [ADDR_W-1:0] i_addr                 = 4'h0;
   logic [DATA_W-1:0] i_wdata                = 32'h0000_0000;
   logic              i_wr                   = 1'b0;
   logic              i_rd                   = 1'b0;
   logic [DATA_W-1:0] o_rdata;
   logic              o_watchdog_reset_out;
   logic              o_running;
   logic [2:0]        osc_div                = 3'h0;
   int                osc_ticks              = 0;
   int                fail_count             = 0;
   int                check_count            = 0;

   iwd_watchdog i_iwd_watchdog
   (
      .i_core_clk             (i_core_clk),
      .i_resetn               (i_resetn),
      .i_clk_en               (i_clk_en),
      .i_low_speed_oscillator (i_low_speed_oscillator),
      .i_hw_watchdog          (i_hw_watchdog),
      .i_addr                 (i_addr),
      .i_wdata                (i_wdata),
      .i_wr                   (i_wr),
      .i_rd                   (i_rd),
      .o_rdata                (o_rdata),
      .o_watchdog_reset_out   (o_watchdog_reset_out),
      .o_running              (o_running)
   );

   always #5 i_core_clk = ~i_core_clk;

   // oscillator: 8 core cycles a period, 4 high and 4 low
   always @(posedge i_core_clk)
   begin
      osc_div <= osc_div + 3'h1;
      i_low_speed_oscillator <= osc_div[2];
      if (osc_div == 3'h4)
         osc_ticks <= osc_ticks + 1;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1 d = o_rdata;
   endtask : rd

   task automatic do_reset(input logic hw);
      @(posedge i_core_clk);
      i_resetn      <= 1'b0;
      i_hw_watchdog <= hw;
      repeat (4) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      #1;
   endtask : do_reset

   // start a write just after the oscillator fell, far from the next tick
   task automatic wait_osc_low;
      for (int k = 0; k < 9 && osc_div !== 3'h1; k++)
         @(posedge i_core_clk);
      if (osc_div !== 3'h1)
      begin
         fail_count++;
         end_sim();
      end
   endtask : wait_osc_low

   task automatic wait_idle;
      logic [31:0] v;
      v = 32'hFFFF_FFFF;
      for (int n = 0; n < 40 && v[1:0] !== 2'b00; n++)
         rd(OFF_STAT, v);
      if (v[1:0] !== 2'b00)
      begin
         fail_count++;
         end_sim();
      end
   endtask : wait_idle

   task automatic cfg(input logic [2:0] ps, input logic [11:0] rl);
      wait_idle();
      wr(OFF_KEY, {16'h0000, KEY_UNLOCK});
      wr(OFF_DIV, {29'h0, ps});
      wr(OFF_RLD, {20'h0, rl});
      wait_idle();
   endtask : cfg

   task automatic fire_ticks(output int t);
      int s;
      s = osc_ticks;
      wr(OFF_KEY, {16'h0000, KEY_RELOAD});
      for (int n = 0; n < 6000 && o_watchdog_reset_out !== 1'b1; n++)
         @(posedge i_core_clk);
      if (o_watchdog_reset_out !== 1'b1)
      begin
         fail_count++;
         end_sim();
      end
      t = osc_ticks - s;
   endtask : fire_ticks

   task automatic t_reset;
      logic [31:0] v;
      do_reset(1'b0);
      rd(OFF_KEY, v);
      chk(v, 32'h0000_0000);
      rd(OFF_DIV, v);
      chk(v, 32'h0000_0000);
      rd(OFF_RLD, v);
      chk(v, 32'h0000_0FFF);
      rd(OFF_STAT, v);
      chk(v, 32'h0000_0000);
      rd(4'h2, v);
      chk(v, 32'h0000_0000);
      chk(o_running, 1'b0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_lock;
      logic [31:0] v;
      wr(OFF_DIV, 32'h0000_0005);
      rd(OFF_STAT, v);
      chk(v, 32'h0000_0000);
      rd(OFF_DIV, v);
      chk(v, 32'h0000_0000);
      wr(OFF_KEY, {16'h0000, KEY_START});
      @(posedge i_core_clk);
      #1 chk(o_running, 1'b1);
      $display("test lock done");
   endtask : t_lock

   task automatic t_busy;
      logic [31:0] v;
      wait_idle();
      wr(OFF_KEY, {16'h0000, KEY_UNLOCK});
      wait_osc_low();
      wr(OFF_RLD, 32'h0000_0123);
      rd(OFF_STAT, v);
      chk(v, 32'h0000_0002);
      wait_osc_low();
      wr(OFF_DIV, 32'h0000_0003);
      rd(OFF_STAT, v);
      chk(v[0], 1'b1);
      wait_idle();
      rd(OFF_RLD, v);
      chk(v, 32'h0000_0123);
      rd(OFF_DIV, v);
      chk(v, 32'h0000_0003);
      wr(OFF_KEY, 32'h0000_1234);
      wr(OFF_DIV, 32'h0000_0007);
      wr(OFF_KEY, {16'h0000, KEY_UNLOCK});
      wr(OFF_KEY, {16'h0000, KEY_RELOAD});
      wr(OFF_RLD, 32'h0000_0456);
      wait_idle();
      rd(OFF_DIV, v);
      chk(v, 32'h0000_0003);
      rd(OFF_RLD, v);
      chk(v, 32'h0000_0123);
      $display("test busy done");
   endtask : t_busy

   task automatic t_kick;
      int t;
      cfg(3'h0, 12'h003);
      for (int k = 0; k < 5; k++)
      begin
         wr(OFF_KEY, {16'h0000, KEY_RELOAD});
         repeat (48) @(posedge i_core_clk);
         chk(o_watchdog_reset_out, 1'b0);
      end
      fire_ticks(t);
      chk(t >= 12 && t <= 18, 1'b1);
      @(posedge i_core_clk);
      #1 chk(o_running, 1'b0);
      $display("test kick done");
   endtask : t_kick

   task automatic t_div;
      int t;
      int d;
      for (int c = 0; c < 8; c++)
      begin
         do_reset(1'b0);
         wr(OFF_KEY, {16'h0000, KEY_START});
         cfg(c[2:0], 12'h001);
         fire_ticks(t);
         d = (c >= 6) ? 256 : (4 << c);
         chk(t >= d && t <= 2 * d + 2, 1'b1);
      end
      $display("test divider done");
   endtask : t_div

   task automatic t_hw;
      logic [31:0] v;
      do_reset(1'b1);
      chk(o_running, 1'b1);
      wr(OFF_KEY, {16'h0000, KEY_START});
      @(posedge i_core_clk);
      #1 chk(o_running, 1'b1);
      chk(o_watchdog_reset_out, 1'b0);
      rd(OFF_RLD, v);
      chk(v, 32'h0000_0FFF);
      // reload write made while the clock enable is low is lost
      wr(OFF_KEY, {16'h0000, KEY_UNLOCK});
      i_clk_en <= 1'b0;
      wr(OFF_RLD, 32'h0000_0055);
      i_clk_en <= 1'b1;
      wait_idle();
      rd(OFF_RLD, v);
      chk(v, 32'h0000_0FFF);
      chk(o_running, 1'b1);
      $display("test hardware start done");
   endtask : t_hw

   initial
   begin
      t_reset();
      t_lock();
      t_busy();
      t_kick();
      t_div();
      t_hw();
      end_sim();
   end
endmodule : iwd_watchdog_tb_top
